// ---- bench/adcr_host_model.sv ----
// adcr_host_model: host-side command decoder model driving register writes and reads
`timescale 1ns/10ps
module adcr_host_model
    import adcr_pkg::*;
(
    input  wire logic       sys_clk_i,
    input  wire logic [7:0] rd_data_i,
    input  wire logic       rd_valid_i,
    output adcr_wr_t        wr_o,
    output logic            wr_done_o,
    output logic            wr_abort_o,
    output logic            rd_en_o,
    output logic [7:0]      rd_addr_o
);
    // idle buses start out at a non-zero pattern
    initial begin
        wr_o = '{strobe: 1'h0, addr: 8'hA5, data: 8'h5A};
        wr_done_o = 1'h0;
        wr_abort_o = 1'h0;
        rd_en_o = 1'h0;
        rd_addr_o = 8'hC3;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // one command cycle between falling edges; released buses show the inverse value
    task automatic cmd(input logic stb, input logic [7:0] addr, input logic [7:0] data,
                       input logic done, input logic abort);
        @(negedge sys_clk_i);
        wr_o = '{strobe: stb, addr: addr, data: data};
        wr_done_o = done;
        wr_abort_o = abort;
        @(negedge sys_clk_i);
        wr_o = '{strobe: 1'h0, addr: ~addr, data: ~data};
        wr_done_o = 1'h0;
        wr_abort_o = 1'h0;
    endtask
    // read request, answer sampled in the cycle after it is taken
    task automatic rd(input logic [7:0] addr, output logic [7:0] data, output logic ok);
        @(negedge sys_clk_i);
        rd_en_o = 1'h1;
        rd_addr_o = addr;
        @(negedge sys_clk_i);
        rd_en_o = 1'h0;
        rd_addr_o = ~addr;
        ok = rd_valid_i;
        data = rd_data_i;
    endtask
endmodule

// ---- bench/tb_adc_config_register_bank.sv ----
// tb_adc_config_register_bank: directed tests of the converter configuration registers
`timescale 1ns/10ps
module tb_adc_config_register_bank
    import adcr_pkg::*;
;
    localparam logic [2:0] VAR_T = 3'h6;  // arbitrary value
    localparam logic [4:0] REV_T = 5'h13; // arbitrary value
    logic       sys_clk = 1'h0;
    logic       rst_n = 1'h0;
    logic       conv_ready = 1'h1;
    adcr_wr_t   wr;
    logic       wr_done;
    logic       wr_abort;
    logic       rd_en;
    logic [7:0] rd_addr;
    logic [7:0] rd_data;
    logic       rd_valid;
    adcr_cfg_t  cfg;
    logic       adc_restart;
    logic       ready_out;
    int         n_mismatch = 0;
    int         comparisons = 0;

    // 100 MHz clock
    always #5 sys_clk = ~sys_clk;

    adcr_regs #(.VARIANT_CODE(VAR_T), .REVISION_CODE(REV_T)) dut (
        .sys_clk_i(sys_clk), .rst_n_i(rst_n), .wr_i(wr), .wr_done_i(wr_done),
        .wr_abort_i(wr_abort), .rd_en_i(rd_en), .rd_addr_i(rd_addr),
        .conv_data_ready_i(conv_ready), .rd_data_o(rd_data), .rd_valid_o(rd_valid),
        .cfg_o(cfg), .adc_restart_o(adc_restart), .data_ready_out_o(ready_out));

    adcr_host_model host (
        .sys_clk_i(sys_clk), .rd_data_i(rd_data), .rd_valid_i(rd_valid), .wr_o(wr),
        .wr_done_o(wr_done), .wr_abort_o(wr_abort), .rd_en_o(rd_en), .rd_addr_o(rd_addr));
    ////////////////////////////////////////////////////////////////////////////////
    // comparison, report and verdict helpers
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rd_check(input string what, input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        logic       ok;
        host.rd(addr, d, ok);
        check({what, " valid"}, {7'h0, ok}, 8'h01);
        check(what, d, exp);
    endtask
    task automatic check_cfg(input logic [4:0] flags, input adcr_check_t chk);
        check("cfg flags", {3'h0, cfg.level_shift_enable, cfg.internal_reference_enable,
              cfg.excitation_allowed, cfg.timeout_enable, cfg.status_byte_enable}, {3'h0, flags});
        check("cfg check", {6'h0, cfg.check_mode}, {6'h0, chk});
    endtask
    task automatic check_defaults();
        rd_check("ident", ADDR_IDENT, {VAR_T, REV_T});
        rd_check("power", ADDR_POWER, RST_POWER);
        rd_check("iface", ADDR_IFACE, RST_IFACE);
        rd_check("mode", ADDR_MODE, RST_MODE);
        rd_check("unmapped", 8'h7F, 8'h00);
        check_cfg(5'h0D, CHK_SUM);
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // hang guard
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_mismatch++;
        print_verdict();
    end
    // main sequence
    initial begin
        repeat (2) @(negedge sys_clk);
        rst_n = 1'h1;
        check_defaults();
        // read-only and reserved bits ignore host writes
        host.cmd(1'h1, ADDR_IDENT, 8'hFF, 1'h0, 1'h0);
        rd_check("ident wr", ADDR_IDENT, {VAR_T, REV_T});
        host.cmd(1'h1, ADDR_POWER, 8'hFE, 1'h0, 1'h0);
        rd_check("power wr", ADDR_POWER, 8'h12);
        check_cfg(5'h11, CHK_SUM);
        host.cmd(1'h1, ADDR_POWER, 8'h00, 1'h0, 1'h0);
        rd_check("power clr", ADDR_POWER, 8'h00);
        host.cmd(1'h1, ADDR_POWER, 8'h01, 1'h0, 1'h0);
        rd_check("power ref", ADDR_POWER, 8'h01);
        // every check-byte mode with time-out and status toggled
        for (int m = 0; m < 4; m++) begin
            host.cmd(1'h1, ADDR_IFACE, {4'hF, m[0], m[1], m[1:0]}, 1'h0, 1'h0);
            rd_check("iface wr", ADDR_IFACE, {4'h0, m[0], m[1], m[1:0]});
            check_cfg({3'h3, m[0], m[1]}, adcr_check_t'(m[1:0]));
        end
        // staged mode byte applies only on completion
        conv_ready = 1'h0;
        host.cmd(1'h1, ADDR_MODE, 8'hC5, 1'h0, 1'h0);
        rd_check("mode staged", ADDR_MODE, RST_MODE);
        check("ready idle", {7'h0, ready_out}, 8'h00);
        host.cmd(1'h0, ADDR_MODE, 8'h00, 1'h1, 1'h0);
        check("restart", {7'h0, adc_restart}, 8'h01);
        @(negedge sys_clk);
        check("ready high", {7'h0, ready_out}, 8'h01);
        check("restart end", {7'h0, adc_restart}, 8'h00);
        rd_check("mode done", ADDR_MODE, 8'hC5);
        check("cfg mode", cfg.mode, 8'hC5);
        check("single shot", {7'h0, cfg.single_shot}, 8'h01);
        // cut-short command discards the staged byte
        host.cmd(1'h1, ADDR_MODE, 8'h3A, 1'h0, 1'h0);
        host.cmd(1'h0, ADDR_MODE, 8'h00, 1'h1, 1'h1);
        check("no restart", {7'h0, adc_restart}, 8'h00);
        host.cmd(1'h0, ADDR_MODE, 8'h00, 1'h1, 1'h0);
        check("empty done", {7'h0, adc_restart}, 8'h00);
        rd_check("mode kept", ADDR_MODE, 8'hC5);
        // byte and completion in one cycle
        host.cmd(1'h1, ADDR_MODE, 8'h3A, 1'h1, 1'h0);
        check("restart same", {7'h0, adc_restart}, 8'h01);
        rd_check("mode same", ADDR_MODE, 8'h3A);
        check("continuous", {7'h0, cfg.single_shot}, 8'h00);
        // reset in mid-run restores every default
        @(negedge sys_clk);
        rst_n = 1'h0;
        repeat (2) @(negedge sys_clk);
        rst_n = 1'h1;
        check_defaults();
        print_verdict();
    end
endmodule

// ---- common/adcr_pkg.sv ----
// adcr_pkg: constants and types of the converter configuration register bank
package adcr_pkg;
    // register addresses
    localparam logic [7:0] ADDR_IDENT = 8'h00;
    localparam logic [7:0] ADDR_POWER = 8'h01;
    localparam logic [7:0] ADDR_IFACE = 8'h02;
    localparam logic [7:0] ADDR_MODE  = 8'h03;
    // reset values
    localparam logic [7:0] RST_POWER  = 8'h11;
    localparam logic [7:0] RST_IFACE  = 8'h05;
    localparam logic [7:0] RST_MODE   = 8'h00;
    // writable bit masks, reserved bits read zero
    localparam logic [7:0] POWER_WMASK = 8'h13;
    localparam logic [7:0] IFACE_WMASK = 8'h0F;
    // field positions
    localparam int PWR_RESET_BIT  = 4;
    localparam int PWR_LSHIFT_BIT = 1;
    localparam int PWR_REF_BIT    = 0;
    localparam int IF_TIMEOUT_BIT = 3;
    localparam int IF_STATUS_BIT  = 2;
    localparam int IF_CHECK_LSB   = 0;
    // identification field widths
    localparam int VARIANT_W  = 3;
    localparam int REVISION_W = 5;

    // check byte appended to conversion data read-back
    typedef enum logic [1:0] {
        CHK_NONE = 2'h0,
        CHK_SUM  = 2'h1,
        CHK_CRC  = 2'h2,
        CHK_RSVD = 2'h3
    } adcr_check_t;

    // conversion-mode register layout, bit 7 down to bit 0
    typedef struct packed {
        logic       reference_polarity_reverse;
        logic       conversion_run_mode;
        logic [1:0] chop_select;
        logic [3:0] conversion_delay;
    } adcr_mode_t;

    // one byte written by the command decoder
    typedef struct packed {
        logic       strobe;
        logic [7:0] addr;
        logic [7:0] data;
    } adcr_wr_t;

    // configuration presented to the analog and interface logic
    typedef struct packed {
        logic        level_shift_enable;
        logic        internal_reference_enable;
        logic        excitation_allowed;
        logic        timeout_enable;
        logic        status_byte_enable;
        adcr_check_t check_mode;
        adcr_mode_t  mode;
        logic        single_shot;
    } adcr_cfg_t;

    // group staging states
    typedef enum logic [1:0] {
        GB_IDLE = 2'b01,
        GB_PEND = 2'b10
    } adcr_gb_state_t;
endpackage

// ---- verilog/adcr_group_buf.sv ----
// adcr_group_buf: staging buffer for group-updated register bytes
`timescale 1ns/10ps
module adcr_group_buf
    import adcr_pkg::*;
(
    input  wire logic       sys_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       stage_i,
    input  wire logic [7:0] data_i,
    input  wire logic       done_i,
    input  wire logic       abort_i,
    output logic            commit_o,
    output logic [7:0]      data_o
);
    adcr_gb_state_t state;
    logic [7:0]     held;

    // hold the latest staged byte until the command ends
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            state <= GB_IDLE;
            held  <= 8'h00;
        end else if (abort_i) begin
            state <= GB_IDLE; // cut-short command drops staged data [R14]
        end else if (done_i) begin
            state <= GB_IDLE;
        end else if (stage_i) begin
            state <= GB_PEND;
            held  <= data_i;
        end
    end

    // apply only on completion; a byte staged with done still counts
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            commit_o <= 1'b0;
            data_o   <= 8'h00;
        end else begin
            commit_o <= 1'b0;
            unique case (state)
                GB_IDLE: begin
                    if (done_i && !abort_i && stage_i) begin
                        commit_o <= 1'b1; // [R14]
                        data_o   <= data_i;
                    end
                end
                GB_PEND: begin
                    if (done_i && !abort_i) begin
                        commit_o <= 1'b1; // [R14]
                        data_o   <= stage_i ? data_i : held;
                    end
                end
            endcase
        end
    end
endmodule

// ---- verilog/adcr_regs.sv ----
// adcr_regs: identification, power, interface and conversion-mode registers
//
// Contract
// [R01] identification upper three bits hold a read-only variant code
// [R02] identification lower five bits hold a read-only silicon revision code
// [R03] reset indicator set by every reset, cleared only by host writing zero
// [R04] power bit 1 enables the level-shift voltage, resets disabled
// [R05] power bit 0 enables the internal reference, resets enabled
// [R06] power register resets to 11h, reserved bits read zero
// [R07] interface bit 3 enables serial time-out, resets disabled
// [R08] interface bit 2 includes the status byte, resets included
// [R09] check field selects none, checksum, CRC; 11 reserved; resets checksum
// [R10] interface register resets to 05h, reserved bits read zero
// [R11] conversion-mode register holds polarity, run mode, chop, delay; resets 00h
// [R12] run-mode zero means continuous, one means single-shot conversion
// [R13] writing conversion-mode restarts conversion and drives data ready high
// [R14] conversion-mode block writes apply on completion, discarded if cut short
// [R15] writes to read-only and reserved bits are ignored
// [R16] every field returns to reset value on reset, indicator reads one
`timescale 1ns/10ps
module adcr_regs
    import adcr_pkg::*;
#(
    parameter logic [VARIANT_W-1:0]  VARIANT_CODE  = 3'h5, // arbitrary value
    parameter logic [REVISION_W-1:0] REVISION_CODE = 5'h0A // arbitrary value
) (
    input  wire logic       sys_clk_i,
    input  wire logic       rst_n_i,
    input  wire adcr_wr_t   wr_i,
    input  wire logic       wr_done_i,
    input  wire logic       wr_abort_i,
    input  wire logic       rd_en_i,
    input  wire logic [7:0] rd_addr_i,
    input  wire logic       conv_data_ready_i,
    output logic [7:0]      rd_data_o,
    output logic            rd_valid_o,
    output adcr_cfg_t       cfg_o,
    output logic            adc_restart_o,
    output logic            data_ready_out_o
);
    ////////////////////////////////////////////////////////////////////////////////
    // storage
    logic       reset_flag;
    logic       level_shift_enable;
    logic       internal_reference_enable;
    logic       timeout_enable;
    logic       status_byte_enable;
    logic [1:0] check_sel;
    adcr_mode_t mode;
    logic       commit;
    logic [7:0] commit_data;
    logic [7:0] power_view;
    logic [7:0] iface_view;
    logic [7:0] ident_view;
    logic       wr_power;
    logic       wr_iface;
    logic       wr_mode;

    // address decode; the identification address takes no write [R15]
    assign wr_power = wr_i.strobe && (wr_i.addr == ADDR_POWER);
    assign wr_iface = wr_i.strobe && (wr_i.addr == ADDR_IFACE);
    assign wr_mode  = wr_i.strobe && (wr_i.addr == ADDR_MODE);

    ////////////////////////////////////////////////////////////////////////////////
    // power register, takes effect as each byte arrives
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            reset_flag                <= RST_POWER[PWR_RESET_BIT];  // [R03] [R16]
            level_shift_enable        <= RST_POWER[PWR_LSHIFT_BIT]; // [R04]
            internal_reference_enable <= RST_POWER[PWR_REF_BIT];    // [R05]
        end else if (wr_power) begin
            reset_flag                <= wr_i.data[PWR_RESET_BIT];  // [R03]
            level_shift_enable        <= wr_i.data[PWR_LSHIFT_BIT]; // [R04]
            internal_reference_enable <= wr_i.data[PWR_REF_BIT];    // [R05]
        end
    end

    // interface register
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            timeout_enable     <= RST_IFACE[IF_TIMEOUT_BIT];              // [R07]
            status_byte_enable <= RST_IFACE[IF_STATUS_BIT];               // [R08]
            check_sel          <= RST_IFACE[IF_CHECK_LSB+1:IF_CHECK_LSB]; // [R09]
        end else if (wr_iface) begin
            timeout_enable     <= wr_i.data[IF_TIMEOUT_BIT];              // [R07]
            status_byte_enable <= wr_i.data[IF_STATUS_BIT];               // [R08]
            check_sel          <= wr_i.data[IF_CHECK_LSB+1:IF_CHECK_LSB]; // [R09]
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // conversion-mode register, updated only from the group buffer
    adcr_group_buf u_group (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .stage_i   (wr_mode),
        .data_i    (wr_i.data),
        .done_i    (wr_done_i),
        .abort_i   (wr_abort_i),
        .commit_o  (commit),
        .data_o    (commit_data)
    );

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            mode <= adcr_mode_t'(RST_MODE); // [R11] [R16]
        end else if (commit) begin
            mode <= adcr_mode_t'(commit_data); // [R11] [R14]
        end
    end

    // restart pulse and data-ready drive on a mode update
    assign adc_restart_o = commit; // [R13]

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            data_ready_out_o <= 1'b1;
        end else begin
            data_ready_out_o <= commit ? 1'b1 : conv_data_ready_i; // [R13]
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read views, reserved bits forced to zero
    assign ident_view = {VARIANT_CODE, REVISION_CODE}; // [R01] [R02]
    assign power_view = {3'h0, reset_flag, 2'h0, level_shift_enable,
                         internal_reference_enable} & POWER_WMASK; // [R06]
    assign iface_view = {4'h0, timeout_enable, status_byte_enable,
                         check_sel} & IFACE_WMASK; // [R10]

    // registered read data, unmapped addresses read zero
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            rd_data_o  <= 8'h00;
            rd_valid_o <= 1'b0;
        end else begin
            rd_valid_o <= rd_en_i;
            if (rd_en_i) begin
                unique case (rd_addr_i)
                    ADDR_IDENT: rd_data_o <= ident_view; // [R15]
                    ADDR_POWER: rd_data_o <= power_view;
                    ADDR_IFACE: rd_data_o <= iface_view;
                    ADDR_MODE:  rd_data_o <= mode;
                    default:    rd_data_o <= 8'h00;
                endcase
            end
        end
    end

    // configuration outputs; excitation needs the reference
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            cfg_o <= '0;
        end else begin
            cfg_o.level_shift_enable        <= level_shift_enable;
            cfg_o.internal_reference_enable <= internal_reference_enable;
            cfg_o.excitation_allowed        <= internal_reference_enable; // [R05]
            cfg_o.timeout_enable            <= timeout_enable;
            cfg_o.status_byte_enable        <= status_byte_enable;
            cfg_o.check_mode                <= adcr_check_t'(check_sel); // [R09]
            cfg_o.mode                      <= mode;
            cfg_o.single_shot               <= mode.conversion_run_mode; // [R12]
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    a_ident_read: assert property (rd_en_i && rd_addr_i == ADDR_IDENT |=> // [R01]
        rd_data_o == {VARIANT_CODE, REVISION_CODE} && rd_valid_o)
        else $error("identification read wrong");
    a_ident_stable: assert property (wr_i.strobe && wr_i.addr == ADDR_IDENT // [R15]
        ##[1:2] rd_en_i && rd_addr_i == ADDR_IDENT |=>
        rd_data_o == {VARIANT_CODE, REVISION_CODE})
        else $error("identification changed by write");
    a_power_rsvd_zero: assert property (rd_en_i && rd_addr_i == ADDR_POWER |=> // [R06]
        (rd_data_o & ~POWER_WMASK) == 8'h00)
        else $error("power reserved bits not zero");
    a_iface_rsvd_zero: assert property (rd_en_i && rd_addr_i == ADDR_IFACE |=> // [R10]
        (rd_data_o & ~IFACE_WMASK) == 8'h00)
        else $error("interface reserved bits not zero");
    a_reset_defaults: assert property (!$past(rst_n_i) |-> power_view == RST_POWER // [R16]
        && iface_view == RST_IFACE && mode == RST_MODE)
        else $error("defaults wrong after reset");
    a_flag_clears: assert property (wr_power && !wr_i.data[PWR_RESET_BIT] |=> // [R03]
        !reset_flag ##1 (reset_flag == $past(wr_power && wr_i.data[PWR_RESET_BIT])))
        else $error("reset indicator not cleared by zero write");
    a_power_write: assert property (wr_power |=> // [R04]
        power_view == ($past(wr_i.data) & POWER_WMASK))
        else $error("power write not applied");
    a_iface_write: assert property (wr_iface |-> ##2 // [R07]
        cfg_o.timeout_enable == $past(wr_i.data[IF_TIMEOUT_BIT], 2) &&
        cfg_o.status_byte_enable == $past(wr_i.data[IF_STATUS_BIT], 2))
        else $error("interface write not applied");
    // an earlier completed command may still land while a new byte is staged
    a_mode_deferred: assert property (wr_mode && !wr_done_i |=> // [R14]
        mode == $past(commit ? commit_data : mode))
        else $error("mode applied before completion");
    a_abort_discards: assert property (wr_abort_i |=> !commit ##1 // [R14]
        mode == $past(mode))
        else $error("aborted mode data applied");
    a_restart_ready: assert property (commit |=> data_ready_out_o && // [R13]
        mode == $past(commit_data))
        else $error("restart without data ready");
    a_ready_follow: assert property (!commit |=> // [R13]
        data_ready_out_o == $past(conv_data_ready_i))
        else $error("data ready not passed through");
    a_mode_read: assert property (rd_en_i && rd_addr_i == ADDR_MODE |=> // [R11]
        rd_data_o == $past(mode))
        else $error("mode read wrong");
    a_power_read: assert property (rd_en_i && rd_addr_i == ADDR_POWER |=> // [R06]
        rd_data_o == $past(power_view))
        else $error("power read wrong");
    a_run_mode: assert property (##1 cfg_o.single_shot == $past(mode[6])) // [R12]
        else $error("run mode not presented");

    c_mode_commit: cover property (wr_mode ##[1:4] wr_done_i ##1 commit);
    c_mode_abort:  cover property (wr_mode ##[1:4] wr_abort_i);
    c_flag_clear:  cover property (wr_power && !wr_i.data[PWR_RESET_BIT]);
    c_crc_mode:    cover property (cfg_o.check_mode == CHK_CRC);
endmodule
